// ---- rtl/pcs_core.sv ----
// Program counter, eight-entry circular return stack and indirect window.
// Assumes decoder, interrupt logic and data memory all run on core_clk.
// Software registers are reached over AXI4-Lite; data memory reads are
// combinational, valid in the cycle dmem_req.re is high.
//
// Overview of operation
// - Program counter is thirteen bits, bits 12 down to 0.
// - Low program counter byte is a readable and writable register.
// - Upper counter bits are hidden from software, supplied by the latch.
// - Any reset clears the whole program counter.
// - Writing the low byte loads upper bits from latch bits 4 to 0.
// - Call or goto takes the top two counter bits from latch bits 4:3.
// - Return stack is eight entries of thirteen bits.
// - Stack and its pointer are invisible to software.
// - Calls and interrupt vectoring push the program counter.
// - Return, return with literal and interrupt return pop the stack.
// - Pushes and pops leave the high latch unchanged.
// - Stack is circular; the ninth push overwrites the first entry.
// - No overflow or underflow indication exists.
// - The window has no storage; it accesses the location the pointer names.
// - Window reading itself returns 00h.
// - Window writing itself stores nothing.
// - Effective address is a constant zero bit above the eight-bit pointer.
// - The bank bit has no effect on indirect addressing.
module pcs_core
    import pcs_pkg::*;
#(
    parameter logic [PC_W-1:0] INT_VECTOR = 13'h0004
) (
    // Clock, reset and enable.
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Program-flow commands from decoder and interrupt logic.
    input wire pcs_flow_t flow,
    output logic [PC_W-1:0] pc_out,
    // Indirect data memory port.
    output pcs_dmem_t dmem_req,
    input wire logic [BYTE_W-1:0] dmem_rdata,
    output logic [EA_W-1:0] ind_eff_addr,
    // AXI4-Lite write address and data.
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response.
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read.
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);

    pcs_state_t s_q;
    pcs_state_t s_d;

    // Register index of a byte address; misaligned offsets fall to no register.
    function automatic logic [6:0] reg_index(input logic [AXI_AW-1:0] a);
        reg_index = (a[ADDR_LSB-1:0] == '0) ? a[AXI_AW-1:ADDR_LSB] : '1;
    endfunction : reg_index

    function automatic logic is_mapped(input logic [6:0] idx);
        is_mapped = (idx == IDX_INDIRECT_WINDOW) || (idx == IDX_PC_LOW_BYTE) ||
                    (idx == IDX_BANK_CTRL) || (idx == IDX_FILE_POINTER) ||
                    (idx == IDX_PC_HIGH_LATCH);
    endfunction : is_mapped

    // The window names itself whenever the pointer's bank offset is zero.
    function automatic logic is_window_self(input logic [BYTE_W-1:0] fp);
        is_window_self = (fp[WIN_SEL_W-1:0] == IDX_INDIRECT_WINDOW);
    endfunction : is_window_self

    function automatic logic [EA_W-1:0] eff_addr(input logic bank,
                                                 input logic [BYTE_W-1:0] fp);
        eff_addr = {bank & BANK_BIT_USED, fp};
    endfunction : eff_addr

    logic wr_go;
    logic [6:0] wr_idx;
    logic [6:0] rd_idx;
    logic ar_hs;
    logic [SP_W-1:0] sp_prev;
    logic pcl_sw_write;
    logic [BYTE_W-1:0] rd_byte;

    // Handshake outputs; ready stays low while the block is frozen.
    assign s_axi_awready = ce && !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready = ce && !s_q.w_got && !s_q.bvalid;
    assign s_axi_arready = ce && !s_q.rvalid && !s_q.rd_pend;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    assign pc_out = s_q.pc;
    assign dmem_req = s_q.dm;
    assign ind_eff_addr = eff_addr(s_q.bank, s_q.fp);

    assign wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    assign wr_idx = reg_index(s_q.awaddr);
    assign rd_idx = reg_index(s_axi_araddr);
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign sp_prev = s_q.sp - SP_W'(1);
    assign pcl_sw_write = wr_go && s_q.wstrb0 && (wr_idx == IDX_PC_LOW_BYTE);

    // Read data of the plain registers; the window is handled apart.
    always_comb begin
        rd_byte = '0;
        case (rd_idx)
            IDX_PC_LOW_BYTE: rd_byte = s_q.pc[BYTE_W-1:0];
            IDX_PC_HIGH_LATCH: rd_byte = BYTE_W'(s_q.latch);
            IDX_FILE_POINTER: rd_byte = s_q.fp;
            IDX_BANK_CTRL: rd_byte = BYTE_W'({s_q.bank, 7'h00});
            IDX_INDIRECT_WINDOW: rd_byte = WINDOW_SELF_DATA;
            default: rd_byte = '0;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.dm.re = 1'b0;
        s_d.dm.we = 1'b0;

        // Program flow; interrupt vectoring has the highest priority.
        // latch untouched.
        if (flow.vector) begin
            s_d.stack[s_q.sp] = s_q.pc;
            s_d.sp = s_q.sp + SP_W'(1);
            s_d.pc = INT_VECTOR;
        end else if (flow.call || flow.jump) begin
            if (flow.call) begin
                s_d.stack[s_q.sp] = s_q.pc;
                s_d.sp = s_q.sp + SP_W'(1);
            end
            s_d.pc = {s_q.latch[LATCH_W-1:LATCH_TOP_LSB], flow.jaddr};
        end else if (flow.pop) begin
            s_d.pc = s_q.stack[sp_prev];
            s_d.sp = sp_prev;
        end else if (pcl_sw_write) begin
            s_d.pc = {s_q.latch, s_q.wdata};
        end else if (flow.inc) begin
            s_d.pc = s_q.pc + PC_W'(1);
        end

        // Write address and data are taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata[BYTE_W-1:0];
            s_d.wstrb0 = s_axi_wstrb[0];
        end

        // Write execution once both halves are present.
        if (wr_go) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            if (s_q.wstrb0) begin
                case (wr_idx)
                    IDX_PC_HIGH_LATCH: s_d.latch = s_q.wdata[LATCH_W-1:0];
                    IDX_FILE_POINTER: s_d.fp = s_q.wdata;
                    IDX_BANK_CTRL: s_d.bank = s_q.wdata[BANK_BIT_POS];
                    IDX_INDIRECT_WINDOW: begin
                        if (!is_window_self(s_q.fp)) begin
                            s_d.dm.we = 1'b1;
                            s_d.dm.addr = eff_addr(s_q.bank, s_q.fp);
                            s_d.dm.wdata = s_q.wdata;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Read path; a window read of memory takes one extra cycle.
        if (ar_hs) begin
            s_d.rresp = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            s_d.rdata = 32'(rd_byte);
            if (rd_idx == IDX_INDIRECT_WINDOW && !is_window_self(s_q.fp)) begin
                s_d.rd_pend = 1'b1;
                s_d.dm.re = 1'b1;
                s_d.dm.addr = eff_addr(s_q.bank, s_q.fp);
            end else begin
                s_d.rvalid = 1'b1;
            end
        end
        if (s_q.rd_pend) begin
            s_d.rd_pend = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rdata = 32'(dmem_rdata);
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // Stack wrap is silent: there is deliberately no overflow flag, which
    // lets software treat the stack as a ring at the cost of no error trap.
    // no overflow flag.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.pc <= PC_RESET;
            s_q.latch <= LATCH_RESET;
            s_q.fp <= FP_RESET;
            s_q.sp <= SP_RESET;
            s_q.bresp <= RESP_OKAY;
            s_q.rresp <= RESP_OKAY;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

endmodule : pcs_core

// ---- rtl/pcs_pkg.sv ----
// Package for the program-flow, return-stack and indirect-addressing block.
// Assumes a single core clock shared by the block, the decoder and data memory.
package pcs_pkg;

    // Program counter and stack geometry.
    localparam int PC_W = 13;
    localparam int LATCH_W = 5;
    localparam int JADDR_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int BYTE_W = 8;
    localparam int EA_W = 9;

    // Field positions.
    localparam int LATCH_TOP_LSB = 3;
    localparam int BANK_BIT_POS = 7;
    localparam int WIN_SEL_W = 7;

    // Register indices; the byte address is four times the index.
    localparam logic [6:0] IDX_INDIRECT_WINDOW = 7'h00;
    localparam logic [6:0] IDX_PC_LOW_BYTE = 7'h02;
    localparam logic [6:0] IDX_BANK_CTRL = 7'h03;
    localparam logic [6:0] IDX_FILE_POINTER = 7'h04;
    localparam logic [6:0] IDX_PC_HIGH_LATCH = 7'h0a;
    localparam int ADDR_LSB = 2;
    localparam int AXI_AW = 9;

    // Reset values.
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
    localparam logic [BYTE_W-1:0] FP_RESET = 8'h00;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;

    // The bank bit is kept for software but never reaches the address.
    localparam logic BANK_BIT_USED = 1'b0;

    // Window read of itself and unmapped reads.
    localparam logic [BYTE_W-1:0] WINDOW_SELF_DATA = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // One program-flow command from the decoder and interrupt logic.
    typedef struct packed {
        logic inc;
        logic jump;
        logic call;
        logic vector;
        logic pop;
        logic [JADDR_W-1:0] jaddr;
    } pcs_flow_t;

    // Data memory request for indirect accesses.
    typedef struct packed {
        logic re;
        logic we;
        logic [EA_W-1:0] addr;
        logic [BYTE_W-1:0] wdata;
    } pcs_dmem_t;

    // Whole state of the block.
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [LATCH_W-1:0] latch;
        logic [BYTE_W-1:0] fp;
        logic bank;
        logic [SP_W-1:0] sp;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
        logic aw_got;
        logic w_got;
        logic [AXI_AW-1:0] awaddr;
        logic [BYTE_W-1:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic rd_pend;
        logic [31:0] rdata;
        logic [1:0] rresp;
        pcs_dmem_t dm;
    } pcs_state_t;

endpackage : pcs_pkg

// ---- sim/pcs_core_sva.sv ----
// Checker for the program-flow block, fed from its top-level ports only.
// Assumes ce stays high while bus answers are outstanding.
module pcs_core_sva
    import pcs_pkg::*;
#(
    parameter logic [PC_W-1:0] INT_VECTOR = 13'h0004
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Flow and indirect port.
    input wire pcs_flow_t flow,
    input wire logic [PC_W-1:0] pc_out,
    input wire pcs_dmem_t dmem_req,
    input wire logic [BYTE_W-1:0] dmem_rdata,
    input wire logic [EA_W-1:0] ind_eff_addr,
    // Bus.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence call_s;
        ce && flow.call && !flow.vector;
    endsequence
    sequence pop_s;
        ce && flow.pop && !flow.call && !flow.jump && !flow.vector;
    endsequence
    // The reset check must run while reset is asserted.
    rst_pc_a: assert property (disable iff (1'b0) !rst_n |=> pc_out == PC_RESET)
        else $error("counter not cleared by reset");
    inc_pc_a: assert property (ce && flow == pcs_flow_t'({5'h10, 11'h000}) && !s_axi_awvalid
        && !$past(s_axi_awvalid) && !s_axi_wvalid && !$past(s_axi_wvalid)
        |=> pc_out == $past(pc_out) + 13'h0001) else $error("increment wrong");
    jump_low_a: assert property (ce && (flow.jump || flow.call) && !flow.vector
        |=> pc_out[JADDR_W-1:0] == $past(flow.jaddr)) else $error("jump field wrong");
    vec_pc_a: assert property (ce && flow.vector |=> pc_out == INT_VECTOR)
        else $error("vector address wrong");
    call_ret_a: assert property (call_s ##1 pop_s |=> pc_out == $past(pc_out, 2))
        else $error("return value wrong");
    rd_data_a: assert property (dmem_req.re
        |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(dmem_rdata)})
        else $error("window read data wrong");
    self_rd_a: assert property (ce && s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 9'h000 && ind_eff_addr[6:0] == 7'h00
        |=> s_axi_rvalid && s_axi_rdata == 32'h00000000) else $error("self read not zero");
    self_wr_a: assert property (dmem_req.we |-> ind_eff_addr[6:0] != 7'h00)
        else $error("self write stored");
    eff_addr_a: assert property (dmem_req.re || dmem_req.we |-> dmem_req.addr == ind_eff_addr)
        else $error("indirect address wrong");
    bank_off_a: assert property (ind_eff_addr[EA_W-1] == 1'b0)
        else $error("bank bit reached address");
endmodule : pcs_core_sva

bind pcs_core pcs_core_sva #(.INT_VECTOR(INT_VECTOR)) u_pcs_core_sva (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .flow(flow), .pc_out(pc_out),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .ind_eff_addr(ind_eff_addr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

// ---- sim/pcs_core_tb.sv ----
// Testbench for the program-flow block: bus tasks, flow commands and checks.
// Assumes the data memory model stands on the indirect port.
module pcs_core_tb
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst_n = 1'b0;
    pcs_flow_t flow = '0;
    pcs_dmem_t dmem_req;
    logic [BYTE_W-1:0] dmem_rdata;
    logic [PC_W-1:0] pc_out, exp_q[$];
    logic [EA_W-1:0] ind_eff_addr, awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
    logic ce = 1'b1;
    logic awready, wready, arready, bvalid, rvalid;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp;
    int errors = 0, checked = 0, we_cnt = 0;
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (dmem_req.we) we_cnt++;
    pcs_core u_pcs_core (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .flow(flow),
        .pc_out(pc_out), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
        .ind_eff_addr(ind_eff_addr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    pcs_dmem_model u_pcs_dmem_model (.core_clk(core_clk), .dmem_req(dmem_req),
        .dmem_rdata(dmem_rdata));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Waits for the answer however long it takes; only the watchdog ends a hang.
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", RESP_OKAY, bresp);
        bready <= 1'b0;
        @(negedge core_clk);
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk("rdata", e, rdata);
        chk("rresp", er, rresp);
        rready <= 1'b0;
    endtask : rd
    // Flow commands in struct order: inc, jump, call, vector, pop.
    task automatic fl(input logic [4:0] c, input logic [10:0] j);
        @(posedge core_clk);
        flow <= {c, j};
        @(posedge core_clk);
        flow <= '0;
        @(negedge core_clk);
    endtask : fl
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        int n0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk("pc", PC_RESET, pc_out);
        wr(9'h028, 8'h15);
        wr(9'h008, 8'h34);
        chk("pc", 13'h1534, pc_out);
        rd(9'h008, 32'h34, RESP_OKAY);
        rd(9'h028, 32'h15, RESP_OKAY);
        rd(9'h03c, 32'h0, RESP_SLVERR);
        rd(9'h009, 32'h0, RESP_SLVERR);
        $display("test registers done");
        fl(5'h08, 11'h5a5);
        chk("pc", 13'h15a5, pc_out);
        for (int i = 0; i < 9; i++) begin
            exp_q.push_back(pc_out);
            fl(5'h04, 11'h100 + i[10:0]);
        end
        chk("pc", 13'h1108, pc_out);
        for (int i = 8; i >= 0; i--) begin
            fl(5'h01, 11'h000);
            chk("pop", exp_q[i == 0 ? 8 : i], pc_out);
        end
        wr(9'h008, 8'h00);
        chk("pc", 13'h1500, pc_out);
        fl(5'h0a, 11'h003);
        chk("pc", 13'h0004, pc_out);
        fl(5'h01, 11'h000);
        chk("pc", 13'h1500, pc_out);
        @(posedge core_clk);
        flow <= {5'h04, 11'h7ff};
        @(posedge core_clk);
        flow <= {5'h01, 11'h000};
        fl(5'h00, 11'h000);
        chk("pc", 13'h1500, pc_out);
        wr(9'h028, 8'h1f);
        wr(9'h008, 8'hff);
        fl(5'h10, 11'h000);
        chk("pc", 13'h0000, pc_out);
        // A frozen cycle must neither count nor accept bus traffic.
        @(posedge core_clk);
        ce <= 1'b0;
        flow <= {5'h10, 11'h000};
        @(posedge core_clk);
        flow <= '0;
        @(negedge core_clk);
        chk("pc", 13'h0000, pc_out);
        chk("awready", 1'b0, awready);
        @(posedge core_clk);
        ce <= 1'b1;
        $display("test flow done");
        wr(9'h010, 8'h25);
        wr(9'h000, 8'ha7);
        chk("ea", 9'h025, ind_eff_addr);
        rd(9'h000, 32'ha7, RESP_OKAY);
        wr(9'h00c, 8'h80);
        chk("ea", 9'h025, ind_eff_addr);
        rd(9'h000, 32'ha7, RESP_OKAY);
        wr(9'h010, 8'h00);
        n0 = we_cnt;
        wr(9'h000, 8'h55);
        chk("writes", n0, we_cnt);
        rd(9'h000, 32'h0, RESP_OKAY);
        $display("test indirect done");
        fl(5'h08, 11'h123);
        chk("pc", 13'h1923, pc_out);
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk("pc", PC_RESET, pc_out);
        rd(9'h028, 32'h0, RESP_OKAY);
        $display("test reset done");
        end_of_test();
    end
endmodule : pcs_core_tb

// ---- sim/pcs_dmem_model.sv ----
// Data memory model on the indirect port of the program-flow block.
// Assumes reads are answered combinationally while the read strobe is high.
module pcs_dmem_model
    import pcs_pkg::*;
(
    // Clock.
    input wire logic core_clk,
    // Request and answer.
    input wire pcs_dmem_t dmem_req,
    output logic [BYTE_W-1:0] dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [BYTE_W-1:0] mem_q [0:511];
    logic [BYTE_W-1:0] last_q = 8'h00;
    always @(posedge core_clk) begin
        if (dmem_req.we) begin
            mem_q[dmem_req.addr] <= dmem_req.wdata;
        end
        if (dmem_req.re) begin
            last_q <= mem_q[dmem_req.addr];
        end
    end
    // Outside a read the bus shows the inverse of its last value, so stale data never matches.
    assign dmem_rdata = dmem_req.re ? mem_q[dmem_req.addr] : ~last_q;
endmodule : pcs_dmem_model
